// ===== rtl/frame_alarm_pkg.sv
// constants, types and grading helpers for the frame and pointer alarm monitor
// Functional notes
// - loss of frame after 3 ms without framing
// - two consecutive valid framing patterns clear it
// - check pointer bytes every frame; each invalid one counts toward loss
// - raise pointer loss after eight consecutive invalid frames
// - three consecutive valid pointers clear pointer loss
// - same pointer check for each tributary pointer
// - optical: critical active, minor standby for frame
// - electrical port: frame loss always minor
// - pointer loss: major active, minor standby
package frame_alarm_pkg;

  // ----------------------------------------------------------------
  // sizes
  // ----------------------------------------------------------------
  localparam int NUM_PORTS = 2;
  localparam int NUM_TRIBS = 4;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_MHZ = 250;
  localparam int FRAME_PERIOD_NS = 125000;
  localparam int FRAME_CYCLES_NOM = FRAME_PERIOD_NS * CLK_MHZ / 1000;
  localparam int FRAME_DIV_W = 15;
  localparam int LOF_TIME_US = 3000;
  localparam int LOF_FRAMES = (LOF_TIME_US * 1000) / FRAME_PERIOD_NS;
  localparam logic [4:0] LOF_SET_COUNT = 5'(LOF_FRAMES);
  localparam logic [1:0] LOF_CLEAR_COUNT = 2'h2;
  localparam logic [3:0] LOP_SET_COUNT = 4'h8;
  localparam logic [1:0] LOP_CLEAR_COUNT = 2'h3;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    SEV_NONE = 2'h0,
    SEV_MINOR = 2'h1,
    SEV_MAJOR = 2'h2,
    SEV_CRITICAL = 2'h3
  } sev_level_t;

  typedef struct packed {
    sev_level_t level;
    logic service_affecting;
  } alarm_sev_t;

  typedef struct packed {
    logic frame_seen;
    logic framing_ok;
    logic pointer_ok;
  } rx_ovh_t;

  typedef struct packed {
    logic seen;
    logic ok;
  } trib_ptr_t;

  typedef struct packed {
    logic [3:0] bad;
    logic [1:0] good;
    logic lop;
  } ptr_st_t;

  typedef struct packed {
    logic [4:0] miss;
    logic [1:0] good;
    logic found;
    logic lof;
  } lof_st_t;

  // an alarm that is not raised grades as none; standby always grades minor
  function automatic alarm_sev_t grade_f(input logic raised, input logic at_top,
                                         input sev_level_t top);
    alarm_sev_t s;
    s.level = SEV_NONE;
    s.service_affecting = 1'b0;
    if (raised) begin
      s.level = at_top ? top : SEV_MINOR;
      s.service_affecting = at_top;
    end
    return s;
  endfunction

  // one received pointer, line or tributary
  function automatic ptr_st_t ptr_step_f(input ptr_st_t st, input logic ok);
    ptr_st_t n;
    n = st;
    if (ok) begin
      n.bad = 4'h0;
      if (st.lop) begin
        n.good = st.good + 2'h1;
        if (n.good == LOP_CLEAR_COUNT) begin
          n.lop = 1'b0;
          n.good = 2'h0;
        end
      end
    end else begin
      n.good = 2'h0;
      if (st.bad != LOP_SET_COUNT) begin
        n.bad = st.bad + 4'h1;
      end
      if (n.bad == LOP_SET_COUNT) begin
        n.lop = 1'b1;
      end
    end
    return n;
  endfunction

endpackage

// ===== rtl/frame_alarm_monitor.sv
// per-port loss-of-frame and loss-of-pointer alarm monitor with severity grading
`timescale 1ns/1ps
`default_nettype none
module frame_alarm_monitor
  import frame_alarm_pkg::*;
#(
  parameter int unsigned FRAME_CYCLES = FRAME_CYCLES_NOM
) (
  input wire logic core_clk_i,
  input wire logic reset_i,
  input wire logic card_active_i,
  input wire logic optical_line_card_i,
  input var rx_ovh_t [NUM_PORTS-1:0] rx_ovh_i,
  input var trib_ptr_t [NUM_TRIBS-1:0] trib_ptr_i,
  output logic [NUM_PORTS-1:0] lof_o,
  output logic [NUM_PORTS-1:0] lop_o,
  output logic [NUM_TRIBS-1:0] tributary_pointer_loss_o,
  output alarm_sev_t [NUM_PORTS-1:0] lof_sev_o,
  output alarm_sev_t [NUM_PORTS-1:0] lop_sev_o,
  output alarm_sev_t [NUM_TRIBS-1:0] trib_sev_o
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic act_m;
    logic act_s;
    logic opt_m;
    logic opt_s;
    logic [FRAME_DIV_W-1:0] div;
    lof_st_t [NUM_PORTS-1:0] lof;
    ptr_st_t [NUM_PORTS-1:0] ptr;
    ptr_st_t [NUM_TRIBS-1:0] trib;
    alarm_sev_t [NUM_PORTS-1:0] lof_sev;
    alarm_sev_t [NUM_PORTS-1:0] lop_sev;
    alarm_sev_t [NUM_TRIBS-1:0] trib_sev;
  } state_t;

  state_t st;
  state_t next_st;
  logic tick;

  // nominal frame period keeps running while framing is lost
  assign tick = (st.div == FRAME_DIV_W'(FRAME_CYCLES - 1));

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    next_st = st;
    // card status pins are asynchronous to the frame clock
    next_st.act_m = card_active_i;
    next_st.act_s = st.act_m;
    next_st.opt_m = optical_line_card_i;
    next_st.opt_s = st.opt_m;
    next_st.div = tick ? '0 : st.div + FRAME_DIV_W'(1);
    for (int p = 0; p < NUM_PORTS; p++) begin
      if (rx_ovh_i[p].frame_seen) begin
        if (rx_ovh_i[p].framing_ok) begin
          next_st.lof[p].found = 1'b1;
          next_st.lof[p].miss = 5'h0;
          if (st.lof[p].lof) begin
            next_st.lof[p].good = st.lof[p].good + 2'h1;
            if (next_st.lof[p].good == LOF_CLEAR_COUNT) begin
              next_st.lof[p].lof = 1'b0;
              next_st.lof[p].good = 2'h0;
            end
          end
        end else begin
          next_st.lof[p].good = 2'h0;
        end
        next_st.ptr[p] = ptr_step_f(st.ptr[p], rx_ovh_i[p].pointer_ok);
      end
      // a whole frame period with no valid pattern extends the miss run
      if (tick) begin
        if (!next_st.lof[p].found) begin
          next_st.lof[p].good = 2'h0;
          if (st.lof[p].miss != LOF_SET_COUNT) begin
            next_st.lof[p].miss = st.lof[p].miss + 5'h1;
          end
          if (next_st.lof[p].miss == LOF_SET_COUNT) begin
            next_st.lof[p].lof = 1'b1;
          end
        end
        next_st.lof[p].found = 1'b0;
      end
      next_st.lof_sev[p] = grade_f(next_st.lof[p].lof, st.act_s & st.opt_s,
                                   SEV_CRITICAL);
      next_st.lop_sev[p] = grade_f(next_st.ptr[p].lop, st.act_s, SEV_MAJOR);
    end
    for (int t = 0; t < NUM_TRIBS; t++) begin
      if (trib_ptr_i[t].seen) begin
        next_st.trib[t] = ptr_step_f(st.trib[t], trib_ptr_i[t].ok);
      end
      next_st.trib_sev[t] = grade_f(next_st.trib[t].lop, st.act_s, SEV_MAJOR);
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  always_comb begin
    for (int p = 0; p < NUM_PORTS; p++) begin
      lof_o[p] = st.lof[p].lof;
      lop_o[p] = st.ptr[p].lop;
    end
    for (int t = 0; t < NUM_TRIBS; t++) begin
      tributary_pointer_loss_o[t] = st.trib[t].lop;
    end
  end
  assign lof_sev_o = st.lof_sev;
  assign lop_sev_o = st.lop_sev;
  assign trib_sev_o = st.trib_sev;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (reset_i);

  AST_LOF_RAISE: assert property ($rose(lof_o[0]) |-> $past(tick) &&
      $past(st.lof[0].miss) == LOF_SET_COUNT - 5'h1)
    else $error("frame loss raised without full miss run");
  // reset drops a flag with no clear condition, and the edge after release is not disabled
  AST_LOF_CLEAR: assert property ($fell(lof_o[0]) && !$past(reset_i) |->
      $past(st.lof[0].good) == 2'h1 &&
      $past(rx_ovh_i[0].frame_seen) && $past(rx_ovh_i[0].framing_ok))
    else $error("frame loss cleared without two good patterns");
  AST_PTR_BAD_RUN: assert property (rx_ovh_i[0].frame_seen && !rx_ovh_i[0].pointer_ok &&
      st.ptr[0].bad < 4'h7 |=> st.ptr[0].bad == $past(st.ptr[0].bad) + 4'h1 && st.ptr[0].good == 2'h0)
    else $error("invalid pointer not counted");
  AST_LOP_RAISE: assert property ($rose(lop_o[0]) |-> $past(st.ptr[0].bad) == 4'h7 &&
      $past(rx_ovh_i[0].frame_seen) && !$past(rx_ovh_i[0].pointer_ok))
    else $error("pointer loss raised early or late");
  AST_LOP_CLEAR: assert property ($fell(lop_o[0]) && !$past(reset_i) |->
      $past(st.ptr[0].good) == 2'h2 &&
      $past(rx_ovh_i[0].pointer_ok))
    else $error("pointer loss cleared without three good pointers");
  AST_TRIB_RAISE: assert property ($rose(tributary_pointer_loss_o[0]) |->
      $past(st.trib[0].bad) == 4'h7 && $past(trib_ptr_i[0].seen) && !$past(trib_ptr_i[0].ok))
    else $error("tributary pointer loss raised wrongly");
  AST_LOF_SEV_OPTICAL: assert property (lof_o[0] && $past(st.act_s) && $past(st.opt_s) |->
      lof_sev_o[0].level == SEV_CRITICAL && lof_sev_o[0].service_affecting)
    else $error("optical active frame loss not critical");
  AST_LOF_SEV_MINOR: assert property (lof_o[0] && !($past(st.act_s) && $past(st.opt_s)) |->
      lof_sev_o[0].level == SEV_MINOR && !lof_sev_o[0].service_affecting)
    else $error("frame loss not graded minor");
  AST_LOP_SEV: assert property (lop_o[0] |-> lop_sev_o[0].service_affecting == $past(st.act_s) &&
      lop_sev_o[0].level == ($past(st.act_s) ? SEV_MAJOR : SEV_MINOR))
    else $error("pointer loss graded wrongly");
  AST_RESET_CLEAR: assert property ($past(reset_i) |-> lof_o == '0 && lop_o == '0 &&
      tributary_pointer_loss_o == '0)
    else $error("alarm survived reset");
  AST_MISS_ON_TICK: assert property ($changed(st.lof[0].miss) && st.lof[0].miss != 5'h0 |->
      $past(tick))
    else $error("miss count moved off a frame period");

  COV_LOF_CYCLE: cover property ($rose(lof_o[0]) ##[1:1000] $fell(lof_o[0]));
  COV_LOP_RAISE: cover property ($rose(lop_o[1]));
  COV_TRIB_CLEAR: cover property ($fell(tributary_pointer_loss_o[0]));

endmodule // frame_alarm_monitor
`default_nettype wire

// ===== verif/line_source.sv
// upstream line transmitter model feeding frame and pointer overhead
`timescale 1ns/1ps
`default_nettype none
module line_source
  import frame_alarm_pkg::*;
(
  input wire logic core_clk_i,
  output var rx_ovh_t [NUM_PORTS-1:0] rx_ovh_o,
  output var trib_ptr_t [NUM_TRIBS-1:0] trib_ptr_o
);
  // ------------------------------
  // frame sender
  // ------------------------------
  initial begin
    rx_ovh_o = '0;
    trib_ptr_o = '0;
  end
  // one frame pulse on all ports and tributaries, then a gap; qualifiers flip
  // while idle so a stale level can never pass for a valid pattern
  task automatic frame(input logic fok, input logic pok, input logic tok, input int gap);
    @(posedge core_clk_i);
    rx_ovh_o <= {NUM_PORTS{1'b1, fok, pok}};
    trib_ptr_o <= {NUM_TRIBS{1'b1, tok}};
    @(posedge core_clk_i);
    rx_ovh_o <= {NUM_PORTS{1'b0, ~fok, ~pok}};
    trib_ptr_o <= {NUM_TRIBS{1'b0, ~tok}};
    repeat (gap) @(posedge core_clk_i);
    #1;
  endtask
endmodule // line_source
`default_nettype wire

// ===== verif/test_sonet_frame_pointer_alarm_monitor.sv
// self-checking bench for the frame and pointer alarm monitor
`timescale 1ns/1ps
`default_nettype none
module test_sonet_frame_pointer_alarm_monitor
  import frame_alarm_pkg::*;
;
  // ------------------------------
  // harness
  // ------------------------------
  // short frame period keeps the 24-period frame-loss wait cheap
  localparam int FC = 20;
  logic core_clk_i = 1'b0;
  logic reset_i = 1'b1;
  logic act = 1'b0;
  logic opt = 1'b0;
  rx_ovh_t [NUM_PORTS-1:0] ovh;
  trib_ptr_t [NUM_TRIBS-1:0] trib;
  logic [NUM_PORTS-1:0] lof, lop;
  logic [NUM_TRIBS-1:0] tpl;
  alarm_sev_t [NUM_PORTS-1:0] lof_sev, lop_sev;
  alarm_sev_t [NUM_TRIBS-1:0] trib_sev;
  int failures = 0;
  int total_checks = 0;
  always #2 core_clk_i = ~core_clk_i;
  line_source P (.core_clk_i(core_clk_i), .rx_ovh_o(ovh), .trib_ptr_o(trib));
  frame_alarm_monitor #(.FRAME_CYCLES(FC)) DUT (
    .core_clk_i(core_clk_i), .reset_i(reset_i), .card_active_i(act),
    .optical_line_card_i(opt), .rx_ovh_i(ovh), .trib_ptr_i(trib), .lof_o(lof),
    .lop_o(lop), .tributary_pointer_loss_o(tpl), .lof_sev_o(lof_sev),
    .lop_sev_o(lop_sev), .trib_sev_o(trib_sev));
  // ------------------------------
  // helpers
  // ------------------------------
  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic finish_test();
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // card status is set inside reset so the synchronisers have settled before traffic
  task automatic restart(input logic a, input logic o);
    @(posedge core_clk_i);
    reset_i <= 1'b1;
    act <= a;
    opt <= o;
    repeat (2) @(posedge core_clk_i);
    reset_i <= 1'b0;
    repeat (3) @(posedge core_clk_i);
    #1;
  endtask
  task automatic fr(input logic fok, input logic pok, input int n);
    repeat (n) P.frame(fok, pok, pok, 2);
  endtask
  // ------------------------------
  // scenarios
  // ------------------------------
  task automatic lop_case(input logic a, input alarm_sev_t sev);
    restart(a, 1'b1);
    fr(1'b1, 1'b0, 7);
    fr(1'b1, 1'b1, 1);
    fr(1'b1, 1'b0, 7);
    chk("lop restart", 16'({lop, tpl}), 16'h0);
    fr(1'b1, 1'b0, 1);
    chk("lop set", 16'({lof, lop, tpl}), 16'h3f);
    chk("lop sev", 16'(lop_sev), 16'({sev, sev}));
    chk("trib sev", 16'(trib_sev), 16'({sev, sev, sev, sev}));
    fr(1'b1, 1'b1, 2);
    fr(1'b1, 1'b0, 1);
    fr(1'b1, 1'b1, 2);
    chk("lop hold", 16'({lop, tpl}), 16'h3f);
    fr(1'b1, 1'b1, 1);
    chk("lop clear", 16'({lop, tpl, lop_sev, trib_sev}), 16'h0);
  endtask
  task automatic lof_case(input logic a, input logic o, input alarm_sev_t sev);
    int n;
    n = 0;
    restart(a, o);
    repeat (23 * FC - 5) @(posedge core_clk_i);
    #1;
    chk("lof early", 16'({lof, lof_sev}), 16'h0);
    while (lof[0] !== 1'b1 && n < 2 * FC) begin
      @(posedge core_clk_i);
      #1;
      n++;
    end
    if (n == 2 * FC) begin
      failures++;
      finish_test();
    end
    chk("lof time", 16'(n > FC - 4 && n < FC + 6), 16'h1);
    chk("lof set", 16'({lof, lop}), 16'hc);
    chk("lof sev", 16'(lof_sev), 16'({sev, sev}));
    P.frame(1'b1, 1'b1, 1'b1, 10);
    P.frame(1'b0, 1'b1, 1'b1, 10);
    P.frame(1'b1, 1'b1, 1'b1, 10);
    chk("lof hold", 16'(lof), 16'h3);
    P.frame(1'b1, 1'b1, 1'b1, 10);
    chk("lof clear", 16'({lof, lof_sev}), 16'h0);
  endtask
  initial begin
    repeat (2) @(posedge core_clk_i);
    lop_case(1'b1, '{SEV_MAJOR, 1'b1});
    lop_case(1'b0, '{SEV_MINOR, 1'b0});
    fr(1'b1, 1'b0, 8);
    restart(1'b1, 1'b1);
    chk("reset flags", 16'({lof, lop, tpl}), 16'h0);
    lof_case(1'b1, 1'b1, '{SEV_CRITICAL, 1'b1});
    lof_case(1'b0, 1'b1, '{SEV_MINOR, 1'b0});
    lof_case(1'b1, 1'b0, '{SEV_MINOR, 1'b0});
    finish_test();
  end
endmodule // test_sonet_frame_pointer_alarm_monitor
`default_nettype wire
